// ### inc/srg_map.vh
// status reporting groups: codes, field positions, preset values
`ifndef SRG_MAP_VH
`define SRG_MAP_VH

// width of the stored part of every group register (bit 15 always reads 0)
`define SRG_W 15
`define SRG_PTR_PRESET 15'h7FFF
`define SRG_NTR_PRESET 15'h0000
`define SRG_EN_PRESET 15'h0000

// implemented bits per group
`define SRG_DEV_MASK 15'h001E
`define SRG_OPER_MASK 15'h1C21
`define SRG_CHAN_MASK 15'h0006
`define SRG_MEAS_MASK 15'h0078

// device group bit positions
`define SRG_DEV_A_DET 1
`define SRG_DEV_B_DET 2
`define SRG_DEV_A_ERR 3
`define SRG_DEV_B_ERR 4

// operation group bit positions
`define SRG_OPER_CAL 0
`define SRG_OPER_TRIG 5
`define SRG_OPER_SENSE 10
`define SRG_OPER_LOWER_FAIL 11
`define SRG_OPER_UPPER_FAIL 12

// command group select
`define SRG_GRP_DEV 3'h0
`define SRG_GRP_OPER 3'h1
`define SRG_GRP_CAL 3'h2
`define SRG_GRP_LOWER_FAIL 3'h3
`define SRG_GRP_SENSE 3'h4
`define SRG_GRP_TRIG 3'h5
`define SRG_GRP_UPPER_FAIL 3'h6
`define SRG_GRP_COMMON 3'h7

// register select inside a status group
`define SRG_REG_COND 3'h0
`define SRG_REG_EVENT 3'h1
`define SRG_REG_ENABLE 3'h2
`define SRG_REG_PTR 3'h3
`define SRG_REG_NTR 3'h4

// register select inside the common group
`define SRG_REG_ESE 3'h0
`define SRG_REG_SRE 3'h1
`define SRG_REG_SESR 3'h2
`define SRG_REG_STB 3'h3
`define SRG_REG_EQEN 3'h4

// status byte bit positions
`define SRG_STB_DEV 1
`define SRG_STB_ERRQ 2
`define SRG_STB_ESB 5
`define SRG_STB_RQS 6
`define SRG_STB_OPER 7
`define SRG_EQEN_PRESET 1'b1

`endif

// ### verif/srg_bench.sv
// self-checking bench for the status reporting groups
`timescale 1ns/1ns
`include "srg_map.vh"
module srg_bench;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [2:0] ctl = 3'h0;
	logic [3:0] dev_in = 4'h0;
	logic [13:0] sub_in = 14'h0000;
	logic [7:0] sesr_in = 8'h00;
	logic err_in = 1'b0;
	wire srq;
	logic [13:0] sdrv [2:6] = '{14'h0001, 14'h0040, 14'h0010, 14'h0004, 14'h0400};
	logic [15:0] scnd [2:6] = '{16'h0002, 16'h0008, 16'h0002, 16'h0002, 16'h0008};
	logic [15:0] obit [2:6] = '{16'h0001, 16'h0800, 16'h0400, 16'h0020, 16'h1000};
	wire cmd_valid, cmd_write, rsp_valid, rsp_err, dev_summary, oper_summary;
	wire [2:0] cmd_group, cmd_reg;
	wire [15:0] cmd_wdata, rsp_data;
	wire [7:0] status_byte;
	int mismatches = 0;
	int compares = 0;
	logic [15:0] q;
	logic e;
	always #5 clk = ~clk;
	srg_host host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_group(cmd_group),
		.cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_data(rsp_data));
	srg_top DUT (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_group(cmd_group),
		.cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_data(rsp_data),
		.cls_cmd(ctl[0]), .rst_cmd(ctl[1]), .preset_cmd(ctl[2]), .ch_a_present(dev_in[0]), .ch_b_present(dev_in[1]),
		.ch_a_error(dev_in[2]), .ch_b_error(dev_in[3]), .cal_busy(sub_in[1:0]), .trig_wait(sub_in[3:2]),
		.sense_busy(sub_in[5:4]), .lower_limit_fail(sub_in[9:6]), .upper_limit_fail(sub_in[13:10]),
		.sesr_set(sesr_in), .err_push(err_in), .status_byte(status_byte), .service_request(srq),
		.dev_summary(dev_summary), .oper_summary(oper_summary));
	task wrap_up;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task chk(input string what, input logic [15:0] exp, got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task chkb(input string what, input logic exp, got);
		chk(what, {15'h0, exp}, {15'h0, got});
	endtask
	task acc(input logic w, input logic [2:0] g, r, input logic [15:0] d);
		host.xfer(w, g, r, d, q, e);
		if (host.timed_out) begin
			mismatches++;
			wrap_up();
		end
	endtask
	task rdc(input logic [2:0] g, r, input logic [15:0] exp, input string what);
		acc(1'b0, g, r, 16'h0000);
		chk(what, exp, q);
	endtask
	task wr(input logic [2:0] g, r, input logic [15:0] d, input logic exp_e);
		acc(1'b1, g, r, d);
		chkb("write refused", exp_e, e);
	endtask
	task pulse(input logic [2:0] k);
		@(negedge clk);
		ctl = k;
		@(negedge clk);
		ctl = 3'h0;
	endtask
	// rises meet the positive filter, falls the negative; only bits 1..4 exist
	function automatic logic [15:0] exp_ev(input logic [3:0] o, n, input logic [15:0] p, m);
		return {11'h000, (~o & n & p[4:1]) | (o & ~n & m[4:1]), 1'b0};
	endfunction
	initial begin
		int g, r, i;
		logic [15:0] d, ptr, ntr, en;
		logic [3:0] o, n;
		void'($urandom(32'h45a9d74a));
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		for (g = 0; g < 7; g++) begin
			rdc(g, `SRG_REG_PTR, 16'h7FFF, "ptr at start");
			rdc(g, `SRG_REG_NTR, 16'h0000, "ntr at start");
			rdc(g, `SRG_REG_ENABLE, 16'h0000, "enable at start");
			rdc(g, `SRG_REG_EVENT, 16'h0000, "event at start");
		end
		rdc(7, `SRG_REG_ESE, 16'h0000, "ese at start");
		rdc(7, `SRG_REG_STB, 16'h0000, "stb at start");
		$display("test reset values done");
		for (g = 0; g < 7; g++) begin
			for (r = 2; r < 5; r++) begin
				d = $urandom | 16'h8000;
				wr(g, r, d, 1'b0);
				rdc(g, r, d & 16'h7FFF, "filter or enable readback");
			end
			wr(g, `SRG_REG_COND, 16'h0001, 1'b1);
			wr(g, `SRG_REG_EVENT, 16'h0001, 1'b1);
			wr(g, 3'h5, 16'h0001, 1'b1);
		end
		$display("test register access done");
		wr(0, `SRG_REG_ENABLE, 16'h001E, 1'b0);
		wr(7, `SRG_REG_ESE, 16'h00A5, 1'b0);
		pulse(3'h2);
		pulse(3'h1);
		rdc(0, `SRG_REG_ENABLE, 16'h001E, "enable after rst and cls");
		pulse(3'h4);
		rdc(7, `SRG_REG_ESE, 16'h00A5, "ese after cls and preset");
		for (g = 0; g < 7; g++) begin
			pulse(3'h4);
			rdc(g, 2 + g % 3, (g % 3 == 1) ? 16'h7FFF : 16'h0000, "after preset");
		end
		@(negedge clk) dev_in = 4'h1;
		repeat (3) @(negedge clk);
		pulse(3'h4);
		pulse(3'h2);
		rdc(0, `SRG_REG_EVENT, 16'h0002, "event kept by preset");
		@(negedge clk) dev_in = 4'h3;
		repeat (3) @(negedge clk);
		pulse(3'h1);
		rdc(0, `SRG_REG_EVENT, 16'h0000, "event after cls");
		$display("test preset and clear done");
		for (g = 2; g < 7; g++) begin
			wr(g, `SRG_REG_ENABLE, 16'h7FFF, 1'b0);
			wr(1, `SRG_REG_ENABLE, obit[g], 1'b0);
			@(negedge clk) sub_in = sdrv[g];
			repeat (4) @(negedge clk);
			rdc(g, `SRG_REG_COND, scnd[g], "sub group condition");
			rdc(1, `SRG_REG_COND, obit[g], "operation condition");
			chkb("operation summary", 1'b1, oper_summary);
			@(negedge clk) sub_in = 14'h0000;
			repeat (3) @(negedge clk);
			rdc(g, `SRG_REG_EVENT, scnd[g], "sub group event");
			rdc(1, `SRG_REG_EVENT, obit[g], "operation event");
			repeat (4) @(negedge clk);
		end
		$display("test operation groups done");
		for (i = 0; i < 24; i++) begin
			ptr = (i > 3) ? $urandom : (i[0] ? 16'h001E : 16'h0000);
			ntr = (i > 3) ? $urandom : (i[1] ? 16'h001E : 16'h0000);
			en = $urandom;
			o = $urandom;
			n = (i > 3) ? $urandom : ~o;
			wr(0, `SRG_REG_PTR, ptr, 1'b0);
			wr(0, `SRG_REG_NTR, ntr, 1'b0);
			wr(0, `SRG_REG_ENABLE, en, 1'b0);
			@(negedge clk) dev_in = o;
			repeat (3) @(negedge clk);
			acc(1'b0, 0, `SRG_REG_EVENT, 16'h0000);
			@(negedge clk) dev_in = n;
			repeat (3) @(negedge clk);
			chkb("device summary", |(exp_ev(o, n, ptr, ntr) & en), dev_summary);
			chkb("status byte device bit", |(exp_ev(o, n, ptr, ntr) & en), status_byte[1]);
			rdc(0, `SRG_REG_COND, {11'h000, n, 1'b0}, "device condition");
			rdc(0, `SRG_REG_EVENT, exp_ev(o, n, ptr, ntr), "device event");
			rdc(0, `SRG_REG_EVENT, 16'h0000, "event after read");
		end
		$display("test device transitions done");
		wr(7, `SRG_REG_SRE, 16'h00FF, 1'b0);
		rdc(7, `SRG_REG_SRE, 16'h00BF, "sre readback");
		wr(7, `SRG_REG_ESE, 16'h0001, 1'b0);
		@(negedge clk) sesr_in = 8'h01;
		err_in = 1'b1;
		@(negedge clk) sesr_in = 8'h00;
		err_in = 1'b0;
		chkb("service request", 1'b1, srq);
		rdc(7, `SRG_REG_STB, 16'h0064, "stb with events");
		rdc(7, `SRG_REG_SESR, 16'h0001, "event status");
		wr(7, `SRG_REG_EQEN, 16'h0000, 1'b0);
		rdc(7, `SRG_REG_EQEN, 16'h0000, "queue enable written");
		pulse(3'h4);
		pulse(3'h2);
		rdc(7, `SRG_REG_EQEN, 16'h0001, "queue enable after preset");
		rdc(7, `SRG_REG_STB, 16'h0044, "stb kept by preset and rst");
		wr(7, `SRG_REG_STB, 16'h0000, 1'b1);
		pulse(3'h1);
		rdc(7, `SRG_REG_STB, 16'h0000, "stb after cls");
		rdc(7, `SRG_REG_SRE, 16'h00BF, "sre after cls and preset");
		rdc(7, `SRG_REG_ESE, 16'h0001, "ese kept by cls and preset");
		$display("test common status done");
		wrap_up();
	end
endmodule

// ### verif/srg_host.sv
// host model issuing one status command at a time
`timescale 1ns/1ns
module srg_host (
	// clock
	input logic clk,
	// command port
	output logic cmd_valid, cmd_write,
	output logic [2:0] cmd_group, cmd_reg,
	output logic [15:0] cmd_wdata,
	input logic rsp_valid, rsp_err,
	input logic [15:0] rsp_data
);
	logic timed_out = 1'b0;
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_group = 3'h0;
		cmd_reg = 3'h0;
		cmd_wdata = 16'h0000;
	end
	task xfer(input logic w, input logic [2:0] g, r, input logic [15:0] d, output logic [15:0] q, output logic e);
		int n;
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_group = g;
		cmd_reg = r;
		cmd_wdata = d;
		@(negedge clk);
		cmd_valid = 1'b0;
		// released data inverted so a design that samples it late sees junk
		cmd_wdata = ~d;
		n = 0;
		while (!rsp_valid && n < 4) begin
			@(negedge clk);
			n++;
		end
		if (rsp_valid !== 1'b1) timed_out = 1'b1;
		q = rsp_data;
		e = rsp_err;
	endtask
endmodule

// ### verif/srg_top_sva.sv
// assertions on the status group command port and summaries
`timescale 1ns/1ns
module srg_chk (
	// clock, reset, command port
	input logic clk, rst_b, cmd_valid, cmd_write,
	input logic [2:0] cmd_group, cmd_reg,
	input logic [15:0] cmd_wdata,
	input logic rsp_valid, rsp_err,
	input logic [15:0] rsp_data,
	// commands and channel state
	input logic cls_cmd, rst_cmd, preset_cmd, ch_a_present, ch_b_present, ch_a_error, ch_b_error,
	input logic [1:0] cal_busy, trig_wait, sense_busy,
	input logic [3:0] lower_limit_fail, upper_limit_fail,
	input logic [7:0] sesr_set,
	input logic err_push,
	// status outputs
	input logic [7:0] status_byte,
	input logic service_request, dev_summary, oper_summary
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire [3:0] dev_in = {ch_b_error, ch_a_error, ch_b_present, ch_a_present};
	wire rd = cmd_valid && !cmd_write;
	wire dev_ev_rd = rd && cmd_group == 3'h0 && cmd_reg == 3'h1;
	// three quiet cycles so the condition register has caught up
	sequence s_settled;
		$stable(dev_in)[*3] ##0 $past(rst_b, 3);
	endsequence
	sequence s_preset_rd;
		preset_cmd ##1 !cmd_valid ##1 (rd && cmd_group != 3'h7 && cmd_reg >= 3'h2 && cmd_reg <= 3'h4);
	endsequence
	property p_top_bit;
		rsp_valid |-> !rsp_data[15];
	endproperty
	property p_ro_refused;
		cmd_valid && cmd_write && cmd_group != 3'h7 && cmd_reg <= 3'h1 |=> rsp_valid && rsp_err && rsp_data == 16'h0000;
	endproperty
	property p_dev_cond;
		s_settled ##0 (rd && cmd_group == 3'h0 && cmd_reg == 3'h0) |=> rsp_data == {11'h0, $past(dev_in), 1'b0};
	endproperty
	property p_cal_cond;
		$stable(cal_busy)[*3] ##0 $past(rst_b, 3) ##0 (rd && cmd_group == 3'h2 && cmd_reg == 3'h0)
			|=> rsp_data == {13'h0, $past(cal_busy), 1'b0};
	endproperty
	property p_trig_cond;
		$stable(trig_wait)[*3] ##0 $past(rst_b, 3) ##0 (rd && cmd_group == 3'h5 && cmd_reg == 3'h0)
			|=> rsp_data == {13'h0, $past(trig_wait), 1'b0};
	endproperty
	property p_ev_clear;
		s_settled ##0 dev_ev_rd ##1 $stable(dev_in)[*2] ##0 dev_ev_rd |=> rsp_data == 16'h0000;
	endproperty
	property p_preset;
		s_preset_rd |=> rsp_data == ($past(cmd_reg) == 3'h3 ? 16'h7FFF : 16'h0000);
	endproperty
	property p_stb_dev;
		status_byte[1] == dev_summary;
	endproperty
	property p_stb_oper;
		status_byte[7] == oper_summary;
	endproperty
	a_top_bit: assert property (p_top_bit) else $error("bit 15 of read data set");
	a_ro_refused: assert property (p_ro_refused) else $error("read-only write not refused");
	a_dev_cond: assert property (p_dev_cond) else $error("device condition wrong");
	a_cal_cond: assert property (p_cal_cond) else $error("calibration condition wrong");
	a_trig_cond: assert property (p_trig_cond) else $error("trigger condition wrong");
	a_ev_clear: assert property (p_ev_clear) else $error("event not cleared by read");
	a_preset: assert property (p_preset) else $error("preset value wrong");
	a_stb_dev: assert property (p_stb_dev) else $error("status byte bit 1 off");
	a_stb_oper: assert property (p_stb_oper) else $error("status byte bit 7 off");
	c_ev_clear: cover property (p_ev_clear);
endmodule
bind srg_top srg_chk u_chk (.*);

// ### verilog/srg_common.v
// status byte, standard event register and error queue flag
`timescale 1ns/1ns
`include "srg_map.vh"

module srg_common (
	// clock and reset
	input wire clk,
	input wire rst_b,
	// command side
	input wire preset,
	input wire clear_st,
	input wire wr_ese,
	input wire wr_sre,
	input wire wr_eqen,
	input wire [7:0] wdata,
	input wire rd_sesr,
	// events
	input wire [7:0] sesr_set,
	input wire err_push,
	input wire dev_summary,
	input wire oper_summary,
	// contents
	output reg [7:0] ese_reg,
	output reg [7:0] sre_reg,
	output reg [7:0] sesr_reg,
	output reg eqen_reg,
	output reg err_pending_reg,
	output wire [7:0] stb,
	output wire srq
);

	wire [7:0] stb_raw;

	assign stb_raw = {oper_summary, 1'b0, |(sesr_reg & ese_reg), 2'b00, err_pending_reg & eqen_reg, dev_summary, 1'b0}; // [RL17]
	assign srq = |(stb_raw & sre_reg & 8'hBF);
	assign stb = stb_raw | {1'b0, srq, 6'h00};

	always @(posedge clk) begin
		if (!rst_b) begin
			ese_reg <= 8'h00; // [RL12]
			sre_reg <= 8'h00;
			sesr_reg <= 8'h00; // [RL11]
			eqen_reg <= `SRG_EQEN_PRESET; // [RL10]
			err_pending_reg <= 1'b0;
		end else begin
			// only start-up clears the event and service request enables; no command touches them except writes
			if (wr_ese)
				ese_reg <= wdata; // [RL12]
			if (wr_sre)
				sre_reg <= wdata & 8'hBF;
			sesr_reg <= ((clear_st || rd_sesr) ? 8'h00 : sesr_reg) | sesr_set; // [RL11]
			err_pending_reg <= (clear_st ? 1'b0 : err_pending_reg) | err_push;
			if (preset)
				eqen_reg <= `SRG_EQEN_PRESET; // [RL10]
			else if (wr_eqen)
				eqen_reg <= wdata[0];
		end
	end

endmodule

// ### verilog/srg_group.v
// one status group: condition, transition filters, sticky event, enable, summary
`timescale 1ns/1ns
`include "srg_map.vh"

module srg_group #(
	parameter [`SRG_W-1:0] MASK = 15'h7FFF
) (
	// clock and reset
	input wire clk,
	input wire rst_b,
	// command side
	input wire preset,
	input wire clear_ev,
	input wire wr_enable,
	input wire wr_ptr,
	input wire wr_ntr,
	input wire [`SRG_W-1:0] wdata,
	input wire rd_event,
	// live condition
	input wire [`SRG_W-1:0] cond_in,
	// register contents
	output reg [`SRG_W-1:0] cond_reg,
	output reg [`SRG_W-1:0] event_reg,
	output reg [`SRG_W-1:0] enable_reg,
	output reg [`SRG_W-1:0] ptr_reg,
	output reg [`SRG_W-1:0] ntr_reg,
	output wire summary
);

	wire [`SRG_W-1:0] cond_next;
	wire [`SRG_W-1:0] rise;
	wire [`SRG_W-1:0] fall;
	wire [`SRG_W-1:0] ev_set;
	wire [`SRG_W-1:0] event_next;

	// unimplemented positions never see a condition, so never an event
	assign cond_next = cond_in & MASK;
	assign rise = cond_next & ~cond_reg;
	assign fall = ~cond_next & cond_reg;
	assign ev_set = (rise & ptr_reg) | (fall & ntr_reg); // [RL5] [RL6] [RL7] [RL8]
	// a set in the clearing cycle survives the clear
	assign event_next = ((rd_event || clear_ev) ? {`SRG_W{1'b0}} : event_reg) | ev_set; // [RL2] [RL11]
	assign summary = |(event_reg & enable_reg); // [RL22]

	always @(posedge clk) begin
		if (!rst_b) begin
			cond_reg <= {`SRG_W{1'b0}};
			event_reg <= {`SRG_W{1'b0}}; // [RL11]
			enable_reg <= `SRG_EN_PRESET; // [RL10]
			ptr_reg <= `SRG_PTR_PRESET; // [RL9]
			ntr_reg <= `SRG_NTR_PRESET;
		end else begin
			cond_reg <= cond_next;
			event_reg <= event_next;
			if (preset) begin
				enable_reg <= `SRG_EN_PRESET; // [RL9] [RL10]
				ptr_reg <= `SRG_PTR_PRESET;
				ntr_reg <= `SRG_NTR_PRESET;
			end else begin
				if (wr_enable)
					enable_reg <= wdata; // [RL3]
				if (wr_ptr)
					ptr_reg <= wdata; // [RL4]
				if (wr_ntr)
					ntr_reg <= wdata;
			end
		end
	end

endmodule

// ### verilog/srg_top.v
// status reporting groups: device, operation and its five sub-groups plus status byte
//
// Operation
// RL1 - condition read returns 0..32767 and leaves the condition unchanged
// RL2 - event read returns latched bits then clears the whole event register
// RL3 - enable writable and readable; bit 15 always reads zero
// RL4 - both transition filters writable and readable; bit 15 always reads zero
// RL5 - rising condition with positive filter bit sets the event bit
// RL6 - falling condition with negative filter bit sets the event bit
// RL7 - both filter bits set: either edge sets the event bit
// RL8 - both filter bits clear: changes never set the event bit
// RL9 - preset loads positive filters 0x7fff, clears negative filters and enables
// RL10 - filters, enables, queue enable preset at start-up and status preset only
// RL11 - events, queue, event status, status byte cleared at start-up and clear-status
// RL12 - event and service request enables cleared only at start-up
// RL13 - device group: bits 1,2 detection, 3,4 error, 5,6 reserved, others zero
// RL14 - detection condition follows connection; event bit marks connection or removal
// RL15 - negative filter catches removal, positive filter catches insertion
// RL16 - channel error bit reads 1 while that channel reports an error
// RL17 - device group summary drives status byte bit 1
// RL18 - operation bits 0,5,10,11,12 are the sub-group summaries; others zero
// RL19 - operation structure: top group plus five full sub-groups
// RL20 - calibration group bits 1,2 show channels zeroing; summary to operation bit 0
// RL21 - trigger group bits 1,2 show channels waiting; summary to operation bit 5
// RL22 - group summary is OR of event AND enable; parent condition follows it
`timescale 1ns/1ns
`include "srg_map.vh"

module srg_top (
	// clock and reset
	input wire clk,
	input wire rst_b,
	// host command port
	input wire cmd_valid,
	input wire cmd_write,
	input wire [2:0] cmd_group,
	input wire [2:0] cmd_reg,
	input wire [15:0] cmd_wdata,
	output reg rsp_valid,
	output reg rsp_err,
	output reg [15:0] rsp_data,
	// common status commands
	input wire cls_cmd,
	input wire rst_cmd,
	input wire preset_cmd,
	// channel state
	input wire ch_a_present,
	input wire ch_b_present,
	input wire ch_a_error,
	input wire ch_b_error,
	input wire [1:0] cal_busy,
	input wire [1:0] trig_wait,
	input wire [1:0] sense_busy,
	input wire [3:0] lower_limit_fail,
	input wire [3:0] upper_limit_fail,
	// standard event and error queue sources
	input wire [7:0] sesr_set,
	input wire err_push,
	// status outputs
	output wire [7:0] status_byte,
	output wire service_request,
	output wire dev_summary,
	output wire oper_summary
);

	localparam W = `SRG_W;
	localparam NGRP = 7;

	wire cmd_rd;
	wire cmd_wr;
	wire [NGRP-1:0] grp_hit;
	wire [NGRP-1:0] wr_en_v;
	wire [NGRP-1:0] wr_ptr_v;
	wire [NGRP-1:0] wr_ntr_v;
	wire [NGRP-1:0] rd_ev_v;
	wire [W-1:0] wdata15;
	wire common_hit;

	wire [W-1:0] cond_dev;
	wire [W-1:0] cond_oper;
	wire [W-1:0] cond_cal;
	wire [W-1:0] cond_lower_fail;
	wire [W-1:0] cond_sense;
	wire [W-1:0] cond_trig;
	wire [W-1:0] cond_upper_fail;

	wire [W*NGRP-1:0] cond_bus;
	wire [W*NGRP-1:0] event_bus;
	wire [W*NGRP-1:0] enable_bus;
	wire [W*NGRP-1:0] ptr_bus;
	wire [W*NGRP-1:0] ntr_bus;
	wire [NGRP-1:0] summ;

	wire [7:0] ese_val;
	wire [7:0] sre_val;
	wire [7:0] sesr_val;
	wire eqen_val;
	wire [7:0] stb_val;

	reg [W-1:0] sel_word;
	reg sel_ok;
	reg [15:0] rsp_data_next;
	reg rsp_err_next;
	integer gi;

	// *RST reaches the status logic only to be ignored, which keeps every
	// status register untouched by it
	wire rst_cmd_unused;
	assign rst_cmd_unused = rst_cmd; // [RL10] [RL11] [RL12]

	assign cmd_rd = cmd_valid && !cmd_write;
	assign cmd_wr = cmd_valid && cmd_write;
	assign common_hit = (cmd_group == `SRG_GRP_COMMON);
	// bit 15 of written data is dropped so it can never read back
	assign wdata15 = cmd_wdata[W-1:0]; // [RL3] [RL4]

	genvar g;
	generate
		for (g = 0; g < NGRP; g = g + 1) begin : dec
			localparam [2:0] GSEL = g;
			assign grp_hit[g] = (cmd_group == GSEL);
			assign wr_en_v[g] = cmd_wr && grp_hit[g] && (cmd_reg == `SRG_REG_ENABLE); // [RL3]
			assign wr_ptr_v[g] = cmd_wr && grp_hit[g] && (cmd_reg == `SRG_REG_PTR); // [RL4]
			assign wr_ntr_v[g] = cmd_wr && grp_hit[g] && (cmd_reg == `SRG_REG_NTR);
			assign rd_ev_v[g] = cmd_rd && grp_hit[g] && (cmd_reg == `SRG_REG_EVENT); // [RL2]
		end
	endgenerate

	// condition vectors
	assign cond_dev = {10'h000, ch_b_error, ch_a_error, ch_b_present, ch_a_present, 1'b0}; // [RL13] [RL14] [RL16]
	assign cond_cal = {12'h000, cal_busy, 1'b0}; // [RL20]
	assign cond_trig = {12'h000, trig_wait, 1'b0}; // [RL21]
	assign cond_sense = {12'h000, sense_busy, 1'b0};
	assign cond_lower_fail = {8'h00, lower_limit_fail, 3'h0};
	assign cond_upper_fail = {8'h00, upper_limit_fail, 3'h0};
	// parent condition follows sub-group summaries
	assign cond_oper = {2'b00, summ[`SRG_GRP_UPPER_FAIL], summ[`SRG_GRP_LOWER_FAIL], summ[`SRG_GRP_SENSE], 4'h0,
		summ[`SRG_GRP_TRIG], 4'h0, summ[`SRG_GRP_CAL]}; // [RL18] [RL20] [RL21] [RL22]

	srg_group #(.MASK(`SRG_DEV_MASK)) u_dev ( // [RL13] [RL15]
		.clk(clk),
		.rst_b(rst_b),
		.preset(preset_cmd),
		.clear_ev(cls_cmd),
		.wr_enable(wr_en_v[0]),
		.wr_ptr(wr_ptr_v[0]),
		.wr_ntr(wr_ntr_v[0]),
		.wdata(wdata15),
		.rd_event(rd_ev_v[0]),
		.cond_in(cond_dev),
		.cond_reg(cond_bus[0*W +: W]),
		.event_reg(event_bus[0*W +: W]),
		.enable_reg(enable_bus[0*W +: W]),
		.ptr_reg(ptr_bus[0*W +: W]),
		.ntr_reg(ntr_bus[0*W +: W]),
		.summary(summ[0])
	);

	srg_group #(.MASK(`SRG_OPER_MASK)) u_oper ( // [RL19]
		.clk(clk),
		.rst_b(rst_b),
		.preset(preset_cmd),
		.clear_ev(cls_cmd),
		.wr_enable(wr_en_v[1]),
		.wr_ptr(wr_ptr_v[1]),
		.wr_ntr(wr_ntr_v[1]),
		.wdata(wdata15),
		.rd_event(rd_ev_v[1]),
		.cond_in(cond_oper),
		.cond_reg(cond_bus[1*W +: W]),
		.event_reg(event_bus[1*W +: W]),
		.enable_reg(enable_bus[1*W +: W]),
		.ptr_reg(ptr_bus[1*W +: W]),
		.ntr_reg(ntr_bus[1*W +: W]),
		.summary(summ[1])
	);

	srg_group #(.MASK(`SRG_CHAN_MASK)) u_cal (
		.clk(clk),
		.rst_b(rst_b),
		.preset(preset_cmd),
		.clear_ev(cls_cmd),
		.wr_enable(wr_en_v[2]),
		.wr_ptr(wr_ptr_v[2]),
		.wr_ntr(wr_ntr_v[2]),
		.wdata(wdata15),
		.rd_event(rd_ev_v[2]),
		.cond_in(cond_cal),
		.cond_reg(cond_bus[2*W +: W]),
		.event_reg(event_bus[2*W +: W]),
		.enable_reg(enable_bus[2*W +: W]),
		.ptr_reg(ptr_bus[2*W +: W]),
		.ntr_reg(ntr_bus[2*W +: W]),
		.summary(summ[2])
	);

	srg_group #(.MASK(`SRG_MEAS_MASK)) u_lower_limit_fail_group (
		.clk(clk),
		.rst_b(rst_b),
		.preset(preset_cmd),
		.clear_ev(cls_cmd),
		.wr_enable(wr_en_v[3]),
		.wr_ptr(wr_ptr_v[3]),
		.wr_ntr(wr_ntr_v[3]),
		.wdata(wdata15),
		.rd_event(rd_ev_v[3]),
		.cond_in(cond_lower_fail),
		.cond_reg(cond_bus[3*W +: W]),
		.event_reg(event_bus[3*W +: W]),
		.enable_reg(enable_bus[3*W +: W]),
		.ptr_reg(ptr_bus[3*W +: W]),
		.ntr_reg(ntr_bus[3*W +: W]),
		.summary(summ[3])
	);

	srg_group #(.MASK(`SRG_CHAN_MASK)) u_sense (
		.clk(clk),
		.rst_b(rst_b),
		.preset(preset_cmd),
		.clear_ev(cls_cmd),
		.wr_enable(wr_en_v[4]),
		.wr_ptr(wr_ptr_v[4]),
		.wr_ntr(wr_ntr_v[4]),
		.wdata(wdata15),
		.rd_event(rd_ev_v[4]),
		.cond_in(cond_sense),
		.cond_reg(cond_bus[4*W +: W]),
		.event_reg(event_bus[4*W +: W]),
		.enable_reg(enable_bus[4*W +: W]),
		.ptr_reg(ptr_bus[4*W +: W]),
		.ntr_reg(ntr_bus[4*W +: W]),
		.summary(summ[4])
	);

	srg_group #(.MASK(`SRG_CHAN_MASK)) u_trig (
		.clk(clk),
		.rst_b(rst_b),
		.preset(preset_cmd),
		.clear_ev(cls_cmd),
		.wr_enable(wr_en_v[5]),
		.wr_ptr(wr_ptr_v[5]),
		.wr_ntr(wr_ntr_v[5]),
		.wdata(wdata15),
		.rd_event(rd_ev_v[5]),
		.cond_in(cond_trig),
		.cond_reg(cond_bus[5*W +: W]),
		.event_reg(event_bus[5*W +: W]),
		.enable_reg(enable_bus[5*W +: W]),
		.ptr_reg(ptr_bus[5*W +: W]),
		.ntr_reg(ntr_bus[5*W +: W]),
		.summary(summ[5])
	);

	srg_group #(.MASK(`SRG_MEAS_MASK)) u_upper_limit_fail_group (
		.clk(clk),
		.rst_b(rst_b),
		.preset(preset_cmd),
		.clear_ev(cls_cmd),
		.wr_enable(wr_en_v[6]),
		.wr_ptr(wr_ptr_v[6]),
		.wr_ntr(wr_ntr_v[6]),
		.wdata(wdata15),
		.rd_event(rd_ev_v[6]),
		.cond_in(cond_upper_fail),
		.cond_reg(cond_bus[6*W +: W]),
		.event_reg(event_bus[6*W +: W]),
		.enable_reg(enable_bus[6*W +: W]),
		.ptr_reg(ptr_bus[6*W +: W]),
		.ntr_reg(ntr_bus[6*W +: W]),
		.summary(summ[6])
	);

	srg_common u_common (
		.clk(clk),
		.rst_b(rst_b),
		.preset(preset_cmd),
		.clear_st(cls_cmd),
		.wr_ese(cmd_wr && common_hit && (cmd_reg == `SRG_REG_ESE)),
		.wr_sre(cmd_wr && common_hit && (cmd_reg == `SRG_REG_SRE)),
		.wr_eqen(cmd_wr && common_hit && (cmd_reg == `SRG_REG_EQEN)),
		.wdata(cmd_wdata[7:0]),
		.rd_sesr(cmd_rd && common_hit && (cmd_reg == `SRG_REG_SESR)),
		.sesr_set(sesr_set),
		.err_push(err_push),
		.dev_summary(summ[0]),
		.oper_summary(summ[1]),
		.ese_reg(ese_val),
		.sre_reg(sre_val),
		.sesr_reg(sesr_val),
		.eqen_reg(eqen_val),
		.err_pending_reg(),
		.stb(stb_val),
		.srq(service_request)
	);

	assign status_byte = stb_val; // [RL17]
	assign dev_summary = summ[0];
	assign oper_summary = summ[1];

	// read selection; the value is taken before the read-clear lands
	always @* begin
		sel_word = {W{1'b0}};
		sel_ok = 1'b0;
		for (gi = 0; gi < NGRP; gi = gi + 1) begin
			if (cmd_group == gi[2:0]) begin
				case (cmd_reg)
				`SRG_REG_COND: begin
					sel_word = cond_bus[gi*W +: W]; // [RL1]
					sel_ok = 1'b1;
				end
				`SRG_REG_EVENT: begin
					sel_word = event_bus[gi*W +: W]; // [RL2]
					sel_ok = 1'b1;
				end
				`SRG_REG_ENABLE: begin
					sel_word = enable_bus[gi*W +: W]; // [RL3]
					sel_ok = 1'b1;
				end
				`SRG_REG_PTR: begin
					sel_word = ptr_bus[gi*W +: W]; // [RL4]
					sel_ok = 1'b1;
				end
				`SRG_REG_NTR: begin
					sel_word = ntr_bus[gi*W +: W];
					sel_ok = 1'b1;
				end
				default: begin
					sel_word = {W{1'b0}};
					sel_ok = 1'b0;
				end
				endcase
			end
		end
	end

	always @* begin
		rsp_data_next = 16'h0000;
		rsp_err_next = 1'b0;
		if (common_hit) begin
			case (cmd_reg)
			`SRG_REG_ESE: rsp_data_next = {8'h00, ese_val};
			`SRG_REG_SRE: rsp_data_next = {8'h00, sre_val};
			`SRG_REG_SESR: rsp_data_next = {8'h00, sesr_val};
			`SRG_REG_STB: rsp_data_next = {8'h00, stb_val};
			`SRG_REG_EQEN: rsp_data_next = {15'h0000, eqen_val};
			default: rsp_err_next = 1'b1;
			endcase
			// status byte and event status are read-only
			if (cmd_write && (cmd_reg == `SRG_REG_SESR || cmd_reg == `SRG_REG_STB))
				rsp_err_next = 1'b1;
		end else begin
			rsp_data_next = {1'b0, sel_word}; // [RL1] [RL3] [RL4]
			rsp_err_next = !sel_ok;
			// condition and event are read-only; a write there is refused
			if (cmd_write && (cmd_reg == `SRG_REG_COND || cmd_reg == `SRG_REG_EVENT))
				rsp_err_next = 1'b1;
		end
		if (cmd_write)
			rsp_data_next = 16'h0000;
	end

	always @(posedge clk) begin
		if (!rst_b) begin
			rsp_valid <= 1'b0;
			rsp_err <= 1'b0;
			rsp_data <= 16'h0000;
		end else begin
			rsp_valid <= cmd_valid;
			rsp_err <= cmd_valid && rsp_err_next;
			rsp_data <= cmd_valid ? rsp_data_next : 16'h0000;
		end
	end

endmodule
